// *** bcr_bcd_field.sv ***
/*
 * one bcd time field: counts from a minimum to a maximum, wraps with a
 * carry pulse, and takes a parallel load.
 * assumes inc and load come from logic on the same clock.
 */
`timescale 1ns/100ps
module bcr_bcd_field #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // control
  input  wire logic       inc,
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  input  wire logic [7:0] min_value,
  input  wire logic [7:0] max_value,
  // result
  output logic      [7:0] value,
  output logic            carry
);
  import bcr_pkg::*;

  // wrap when the top of the range is reached or passed
  assign carry = inc && (value >= max_value);

  // count in bcd; a load beats an increment
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value <= RESET_VALUE;
    end else if (load) begin
      value <= load_value;
    end else if (carry) begin
      value <= min_value;
    end else if (inc) begin
      if (value[3:0] >= 4'h9) begin
        value <= {value[7:4] + 4'h1, 4'h0};
      end else begin
        value <= {value[7:4], value[3:0] + 4'h1};
      end
    end
  end

endmodule

// *** bcr_cfg.svh ***
/*
 * constants for the bcd clock register core: register addresses, bit
 * positions, field masks, reset values and time-base counts.
 * assumes inclusion by bare name from every design file that needs it.
 */
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH

// register addresses
`define BCR_ADDR_CTRL   13'h1ff8
`define BCR_ADDR_SEC    13'h1ff9
`define BCR_ADDR_MIN    13'h1ffa
`define BCR_ADDR_HOUR   13'h1ffb
`define BCR_ADDR_DAY    13'h1ffc
`define BCR_ADDR_DATE   13'h1ffd
`define BCR_ADDR_MONTH  13'h1ffe
`define BCR_ADDR_YEAR   13'h1fff
`define BCR_BLOCK_TAG   10'h3ff

// field indexes of the time registers
`define BCR_IDX_SEC     3'h1
`define BCR_IDX_MIN     3'h2
`define BCR_IDX_HOUR    3'h3
`define BCR_IDX_DAY     3'h4
`define BCR_IDX_DATE    3'h5
`define BCR_IDX_MONTH   3'h6
`define BCR_IDX_YEAR    3'h7

// control bit positions and calibration field
`define BCR_CTRL_WRITE  7
`define BCR_CTRL_READ   6
`define BCR_CTRL_SIGN   5
`define BCR_CAL_MSB     4
`define BCR_SEC_HALT    7
`define BCR_DAY_FT      6

// writable field masks; fixed bits read zero
`define BCR_MASK_SEC    8'h7f
`define BCR_MASK_MIN    8'h7f
`define BCR_MASK_HOUR   8'h3f
`define BCR_MASK_DAY    8'h07
`define BCR_MASK_DATE   8'h3f
`define BCR_MASK_MONTH  8'h1f
`define BCR_MASK_YEAR   8'hff

// bcd limits
`define BCR_MAX_SEC     8'h59
`define BCR_MAX_HOUR    8'h23
`define BCR_MAX_DAY     8'h07
`define BCR_MAX_MONTH   8'h12
`define BCR_MAX_YEAR    8'h99
`define BCR_ONE         8'h01
`define BCR_ZERO        8'h00
`define BCR_DAYS_LONG   8'h31
`define BCR_DAYS_SHORT  8'h30
`define BCR_DAYS_FEB    8'h28
`define BCR_DAYS_LEAP   8'h29
`define BCR_MONTH_FEB   8'h02

// reset values
`define BCR_RST_CTRL    8'h00
`define BCR_RST_HALT    1'b1

// time base
`define BCR_CLOCK_HZ    40000000
`define BCR_OSC_HZ      32768
`define BCR_STAGE_DIV   256
`define BCR_FT_HZ       512
`define BCR_PRE_LAST    8'(`BCR_STAGE_DIV - 1)
`define BCR_PRE_SHORT   8'(`BCR_STAGE_DIV / 2 - 1)
`define BCR_STAGE_LAST  7'(`BCR_OSC_HZ / `BCR_STAGE_DIV - 1)
`define BCR_FT_LAST     5'(`BCR_OSC_HZ / (2 * `BCR_FT_HZ) - 1)

`endif

// *** bcr_core.sv ***
/*
 * bcd clock register core: visible time registers at the top of the
 * memory map, running counters behind them, freeze and load control,
 * oscillator halt, calibration and the frequency-test output.
 * assumes all bus pins and the oscillator pin are asynchronous to clock
 * and that host strobes last several clock cycles.
 */
`timescale 1ns/100ps
`include "bcr_cfg.svh"
module bcr_core (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset_n,
  // memory bus pins
  input  wire bcr_pkg::bcr_bus_type bus,
  output logic               [7:0] dq_out,
  output logic                     dq_oe_n,
  // crystal oscillator pin
  input  wire logic                osc_pin
);
  import bcr_pkg::*;

  bcr_bus_type  bus_s1;          // first synchroniser stage
  bcr_bus_type  bus_s2;          // second synchroniser stage
  logic         osc_s1;          // oscillator first stage
  logic         osc_s2;          // oscillator second stage
  logic         osc_s3;          // edge detect history
  logic         wr_act;          // write strobe active
  logic         wr_act_q;        // write strobe last cycle
  logic  [12:0] wr_addr;         // address held through the write
  bcr_byte_type wr_data;         // data held through the write
  logic         wr_strobe;       // end of a write, one cycle
  logic         rd_act;          // read in the clock block
  bcr_byte_type rd_data;         // read mux
  bcr_byte_type ctrl;            // control and calibration
  logic         osc_halt_bit;    // oscillator stopped
  logic         freq_test_bit;   // frequency test enabled
  bcr_byte_type vis [1:7];       // visible time registers
  logic   [7:0] cnt [1:7];       // running counters
  logic   [7:0] min_vec [1:7];   // range bottoms
  logic   [7:0] max_vec [1:7];   // range tops
  logic   [7:0] mask_vec [1:7];  // writable bits per field
  logic   [7:1] inc_vec;         // increment per field
  logic   [7:1] carry_vec;       // wrap per field
  logic         load_req;        // write bit being cleared
  logic         load_pulse;      // counters take visible values
  logic         update_en;       // refresh of visible registers
  logic         osc_tick;        // one oscillator period
  logic   [7:0] prescale;        // divide-by-256 stage
  logic   [6:0] stage;           // stages within a second
  logic         split_done;      // extra stage already run
  logic   [7:0] pre_last;        // terminal count of prescale
  logic         adj_sec;         // this second is calibrated
  logic         hold_stage;      // split: repeat the stage
  logic         sec_tick;        // one second elapsed
  logic   [5:0] min_cycle;       // minute within the 64 cycle
  logic   [4:0] ft_cnt;          // raw divider for test output
  logic         ft_wave;         // 512 Hz square wave
  logic   [4:0] cal_mag;         // calibration magnitude
  logic         cal_pos;         // calibration sign

  // leap years in bcd, 00 counted as leap
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                (y[3:0] == 4'h8);
    end
  endfunction

  // last date of the month in bcd
  function automatic logic [7:0] last_date(input logic [7:0] m,
                                           input logic [7:0] y);
    if (m == `BCR_MONTH_FEB) begin
      last_date = is_leap(y) ? `BCR_DAYS_LEAP : `BCR_DAYS_FEB;
    end else if ((m == 8'h04) || (m == 8'h06) || (m == 8'h09) ||
                 (m == 8'h11)) begin
      last_date = `BCR_DAYS_SHORT;
    end else begin
      last_date = `BCR_DAYS_LONG;
    end
  endfunction

  // bus pins cross into the clock domain through two stages
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_s1 <= '{addr: '0, chip_en1_n: 1'b1, chip_en2: 1'b0,
                  write_n: 1'b1, out_en_n: 1'b1, data: '0};
      bus_s2 <= '{addr: '0, chip_en1_n: 1'b1, chip_en2: 1'b0,
                  write_n: 1'b1, out_en_n: 1'b1, data: '0};
    end else begin
      bus_s1 <= bus;
      bus_s2 <= bus_s1;
    end
  end

  // oscillator pin synchroniser with a history stage for edges
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // a halted oscillator gives no edges at all
  assign osc_tick = osc_s2 && !osc_s3 && !osc_halt_bit;

  // decode of the synchronised bus
  assign wr_act = !bus_s2.chip_en1_n && bus_s2.chip_en2 &&
                  !bus_s2.write_n;
  assign rd_act = !bus_s2.chip_en1_n && bus_s2.chip_en2 &&
                  bus_s2.write_n && !bus_s2.out_en_n &&
                  (bus_s2.addr[12:3] == `BCR_BLOCK_TAG);
  assign wr_strobe = wr_act_q && !wr_act &&
                     (wr_addr[12:3] == `BCR_BLOCK_TAG);

  // hold address and data while the write lasts; commit at its end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_act_q <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act) begin
        wr_addr <= bus_s2.addr;
        wr_data <= bus_s2.data;
      end
    end
  end

  // control register, oscillator halt and test bits
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl          <= `BCR_RST_CTRL;
      osc_halt_bit  <= `BCR_RST_HALT;
      freq_test_bit <= 1'b0;
    end else if (wr_strobe) begin
      if (wr_addr == `BCR_ADDR_CTRL) begin
        ctrl <= wr_data;
      end
      if (wr_addr == `BCR_ADDR_SEC) begin
        osc_halt_bit <= wr_data[`BCR_SEC_HALT];
      end
      if (wr_addr == `BCR_ADDR_DAY) begin
        freq_test_bit <= wr_data[`BCR_DAY_FT];
      end
    end
  end

  assign cal_mag = ctrl[`BCR_CAL_MSB:0];
  assign cal_pos = ctrl[`BCR_CTRL_SIGN];

  // the write bit falling hands the visible values to the counters
  assign load_req = wr_strobe && (wr_addr == `BCR_ADDR_CTRL) &&
                    !wr_data[`BCR_CTRL_WRITE] && ctrl[`BCR_CTRL_WRITE];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      load_pulse <= 1'b0;
    end else begin
      load_pulse <= load_req;
    end
  end

  // refresh every cycle unless frozen or being loaded; copying whole
  // registers in one edge keeps the update atomic against a freeze
  assign update_en = !ctrl[`BCR_CTRL_READ] &&
                     !ctrl[`BCR_CTRL_WRITE] &&
                     !load_pulse;

  // per-field ranges and masks
  always_comb begin
    min_vec  = '{`BCR_ZERO, `BCR_ZERO, `BCR_ZERO, `BCR_ONE,
                 `BCR_ONE, `BCR_ONE, `BCR_ZERO};
    max_vec  = '{`BCR_MAX_SEC, `BCR_MAX_SEC, `BCR_MAX_HOUR,
                 `BCR_MAX_DAY, last_date(cnt[`BCR_IDX_MONTH],
                 cnt[`BCR_IDX_YEAR]), `BCR_MAX_MONTH, `BCR_MAX_YEAR};
    mask_vec = '{`BCR_MASK_SEC, `BCR_MASK_MIN, `BCR_MASK_HOUR,
                 `BCR_MASK_DAY, `BCR_MASK_DATE, `BCR_MASK_MONTH,
                 `BCR_MASK_YEAR};
  end

  // carry chain: weekday and date both step on the day boundary
  assign inc_vec[1] = sec_tick;
  assign inc_vec[2] = carry_vec[1];
  assign inc_vec[3] = carry_vec[2];
  assign inc_vec[4] = carry_vec[3];
  assign inc_vec[5] = carry_vec[3];
  assign inc_vec[6] = carry_vec[5];
  assign inc_vec[7] = carry_vec[6];

  // the running counters, separate from what the host sees
  genvar gi;
  generate
    for (gi = 1; gi <= 7; gi++) begin : g_field
      localparam logic [7:0] RST = ((gi >= 4) && (gi <= 6)) ?
                                   `BCR_ONE : `BCR_ZERO;
      bcr_bcd_field #(
        .RESET_VALUE (RST)
      ) u_field (
        .clock      (clock),
        .reset_n    (reset_n),
        .inc        (inc_vec[gi]),
        .load       (load_pulse),
        .load_value (vis[gi]),
        .min_value  (min_vec[gi]),
        .max_value  (max_vec[gi]),
        .value      (cnt[gi]),
        .carry      (carry_vec[gi])
      );
    end
  endgenerate

  // visible registers: host writes win, refresh copies otherwise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 1; i <= 7; i++) begin
        vis[i] <= ((i >= 4) && (i <= 6)) ? `BCR_ONE : `BCR_ZERO;
      end
    end else begin
      for (int i = 1; i <= 7; i++) begin
        if (wr_strobe && (wr_addr[2:0] == 3'(i))) begin
          vis[i] <= wr_data & mask_vec[i];
        end else if (update_en) begin
          vis[i] <= cnt[i];
        end
      end
    end
  end

  // calibrated second: first second of each of the first 2N minutes
  assign adj_sec  = (cnt[`BCR_IDX_SEC] == `BCR_ZERO) &&
                    (min_cycle < {cal_mag, 1'b0});
  // negative blanks half a stage; positive runs stage zero twice
  assign pre_last = (adj_sec && !cal_pos && (stage == '0)) ?
                    `BCR_PRE_SHORT : `BCR_PRE_LAST;
  assign hold_stage = adj_sec && cal_pos && (stage == '0) &&
                      !split_done;
  assign sec_tick = osc_tick && (prescale == pre_last) &&
                    (stage == `BCR_STAGE_LAST);

  // divider chain; a load restarts the second
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prescale   <= '0;
      stage      <= '0;
      split_done <= 1'b0;
    end else if (load_pulse) begin
      prescale   <= '0;
      stage      <= '0;
      split_done <= 1'b0;
    end else if (osc_tick) begin
      if (prescale >= pre_last) begin
        prescale <= '0;
        if (hold_stage) begin
          split_done <= 1'b1;
        end else if (stage == `BCR_STAGE_LAST) begin
          stage      <= '0;
          split_done <= 1'b0;
        end else begin
          stage <= stage + 7'h1;
        end
      end else begin
        prescale <= prescale + 8'h1;
      end
    end
  end

  // minute position in the 64-minute calibration cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      min_cycle <= '0;
    end else if (carry_vec[1]) begin
      min_cycle <= min_cycle + 6'h1;
    end
  end

  // raw divider for the test wave; calibration never touches it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ft_cnt  <= '0;
      ft_wave <= 1'b0;
    end else if (osc_tick) begin
      if (ft_cnt == `BCR_FT_LAST) begin
        ft_cnt  <= '0;
        ft_wave <= !ft_wave;
      end else begin
        ft_cnt <= ft_cnt + 5'h1;
      end
    end
  end

  // read mux; fixed bits read as zero
  always_comb begin
    rd_data = '0;
    unique case (bus_s2.addr[2:0])
      3'h0:    rd_data = ctrl;
      3'h1:    rd_data = {osc_halt_bit, vis[1][6:1],
                          freq_test_bit ? ft_wave : vis[1][0]};
      3'h4:    rd_data = {1'b0, freq_test_bit, 3'h0, vis[4][2:0]};
      default: rd_data = vis[bus_s2.addr[2:0]];
    endcase
  end

  // data and enable come from flops, so the pins never glitch
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dq_out  <= '0;
      dq_oe_n <= 1'b1;
    end else begin
      dq_out  <= rd_data;
      dq_oe_n <= !rd_act;
    end
  end

  // frozen registers do not move without a host write
  property p_freeze_hold;
    @(posedge clock) disable iff (!reset_n)
      ctrl[`BCR_CTRL_READ] && !wr_strobe |=> $stable(vis[1]);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold)
    else $error("visible seconds moved while frozen");

  // unfrozen registers follow the counters a cycle later
  property p_refresh;
    @(posedge clock) disable iff (!reset_n)
      update_en && !wr_strobe |=> (vis[7] == $past(cnt[7])) &&
                                  (vis[1] == $past(cnt[1]));
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("visible registers did not refresh together");

  // clearing the write bit loads every counter
  property p_load;
    @(posedge clock) disable iff (!reset_n)
      load_req |=> ##1 (cnt[1] == $past(vis[1])) &&
                       (cnt[7] == $past(vis[7]));
  endproperty
  a_load: assert property (p_load)
    else $error("counters not loaded from visible registers");

  // halted oscillator advances nothing
  property p_halt;
    @(posedge clock) disable iff (!reset_n)
      osc_halt_bit |-> !osc_tick && !sec_tick;
  endproperty
  a_halt: assert property (p_halt)
    else $error("divider advanced while oscillator halted");

  // hours stay within the 24-hour bcd range
  property p_hour_range;
    @(posedge clock) disable iff (!reset_n)
      !load_pulse |=> (cnt[3] <= `BCR_MAX_HOUR) && (cnt[3][3:0] <= 4'h9);
  endproperty
  a_hour_range: assert property (p_hour_range)
    else $error("hour counter out of range");

  // only the first 2N minutes of the cycle are adjusted
  property p_adj_window;
    @(posedge clock) disable iff (!reset_n)
      adj_sec |-> (min_cycle < {cal_mag, 1'b0});
  endproperty
  a_adj_window: assert property (p_adj_window)
    else $error("adjusted second outside calibration window");

  // test wave toggles exactly on the raw divider wrap
  property p_ft_toggle;
    @(posedge clock) disable iff (!reset_n)
      osc_tick && (ft_cnt == `BCR_FT_LAST) |=> ft_wave != $past(ft_wave);
  endproperty
  a_ft_toggle: assert property (p_ft_toggle)
    else $error("test wave failed to toggle");

  // weekday stays between one and seven
  property p_weekday;
    @(posedge clock) disable iff (!reset_n)
      $rose(inc_vec[4]) |=> (cnt[4] >= `BCR_ONE) &&
                            (cnt[4] <= `BCR_MAX_DAY);
  endproperty
  a_weekday: assert property (p_weekday)
    else $error("weekday left its range");

  // negative correction wraps the prescaler at the half-stage count in stage zero
  property p_prescale;
    @(posedge clock) disable iff (!reset_n)
      osc_tick && (prescale == `BCR_PRE_SHORT) && !cal_pos && adj_sec &&
      (stage == '0) |=> (prescale == '0);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("negative correction did not blank half a stage");

endmodule

// *** bcr_core_bench.sv ***
/*
 * bench for the clock core: register table, load, freeze, halt, test wave.
 * assumes a fast oscillator pin, so a full second is never reached.
 */
`timescale 1ns/100ps
module bcr_core_bench;
  import bcr_pkg::*;
  typedef struct packed {
    logic [12:0] a;
    logic [7:0]  w;
    logic [7:0]  e;
  } bcr_row_type;
  // ordinary rows: address, written byte, byte read back
  localparam bcr_row_type rows [7] = '{
    '{13'h1ff9, 8'h59, 8'h59}, '{13'h1ffa, 8'h59, 8'h59},
    '{13'h1ffb, 8'he3, 8'h23}, '{13'h1ffc, 8'h07, 8'h07},
    '{13'h1ffd, 8'h31, 8'h31}, '{13'h1ffe, 8'h12, 8'h12},
    '{13'h1fff, 8'h99, 8'h99}};
  logic         clock;    // 40 MHz system clock
  logic         reset_n;  // asynchronous reset
  logic         osc_pin;  // fast stand-in oscillator
  bcr_bus_type  bus;      // pins from the host model
  logic   [7:0] dq_out;   // read data
  logic         dq_oe_n;  // low while the core drives
  int           mismatches;
  int           cmp_count;
  bcr_byte_type d;
  logic         ok;
  int           n;
  // design and its host
  bcr_core u_dut (.clock(clock), .reset_n(reset_n), .bus(bus),
                  .dq_out(dq_out), .dq_oe_n(dq_oe_n), .osc_pin(osc_pin));
  bcr_host_model u_host (.clock(clock), .bus(bus), .dq_out(dq_out),
                         .dq_oe_n(dq_oe_n));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // oscillator edge every four clocks, well inside the synchroniser
  initial begin
    osc_pin = 1'b0;
    forever begin
      repeat (4) @(posedge clock);
      #1 osc_pin = ~osc_pin;
    end
  end
  task automatic check(input bcr_byte_type seen, input bcr_byte_type exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [12:0] a, input bcr_byte_type exp);
    u_host.rd(a, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
    // a read that never answered ends the run at the report
    if (!ok) print_verdict();
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    mismatches = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    repeat (5) @(posedge clock);
    #1 reset_n = 1'b1;
    rd_chk(13'h1ff8, 8'h00);
    rd_chk(13'h1ff9, 8'h80);
    rd_chk(13'h1ffd, 8'h01);
    u_host.wr(13'h1ff9, 8'h80);
    u_host.wr(13'h1ff9, 8'h00);
    u_host.wr(13'h1ff8, 8'h80);
    foreach (rows[i]) begin
      u_host.wr(rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].e);
    end
    u_host.wr(13'h1ff8, 8'h00);
    rd_chk(13'h1ffa, 8'h59);
    rd_chk(13'h1ffb, 8'h23);
    rd_chk(13'h1fff, 8'h99);
    u_host.wr(13'h1ff8, 8'h40);
    rd_chk(13'h1ffd, 8'h31);
    u_host.wr(13'h1ff8, 8'h00);
    rd_chk(13'h1ffe, 8'h12);
    u_host.rd(13'h0100, d, ok);
    check({7'h00, ok}, 8'h00);
    u_host.wr(13'h1ffc, 8'h41);
    u_host.hold_sec(1100, n);
    check({7'h00, n >= 3 && n <= 5}, 8'h01);
    u_host.wr(13'h1ff8, 8'h3f);
    u_host.hold_sec(1100, n);
    check({7'h00, n >= 3 && n <= 5}, 8'h01);
    u_host.wr(13'h1ffc, 8'h01);
    u_host.wr(13'h1ff9, 8'h80);
    // counters still hold the loaded 59 seconds, so only bit 7 is new
    rd_chk(13'h1ff9, 8'hd9);
    // reset in mid-run: control clears, oscillator halts again
    reset_n = 1'b0;
    repeat (5) @(posedge clock);
    #1 reset_n = 1'b1;
    rd_chk(13'h1ff8, 8'h00);
    rd_chk(13'h1ff9, 8'h80);
    print_verdict();
  end
endmodule

// *** bcr_host_model.sv ***
/*
 * host model: drives the asynchronous memory pins of the clock core.
 * assumes a free-running clock and the three-clock read path of the core.
 */
`timescale 1ns/100ps
module bcr_host_model (
  // clock
  input  wire logic                 clock,
  // memory pins toward the core
  output bcr_pkg::bcr_bus_type      bus,
  input  wire logic           [7:0] dq_out,
  input  wire logic                 dq_oe_n
);
  import bcr_pkg::*;
  // idle at time zero: deselected, strobes inactive
  initial begin
    bus = '{13'h0000, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
  end
  // write strobe held four clocks, then four idle clocks
  task automatic wr(input logic [12:0] a, input bcr_byte_type d);
    @(posedge clock);
    #1 bus = '{a, 1'b0, 1'b1, 1'b0, 1'b1, d};
    repeat (4) @(posedge clock);
    // released data shows the inverse, never the stale byte
    #1 bus = '{a, 1'b1, 1'b0, 1'b1, 1'b1, ~d};
    repeat (4) @(posedge clock);
  endtask
  // read: hold the request until the core drives, bounded wait
  task automatic rd(input logic [12:0] a, output bcr_byte_type d,
                    output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clock);
    #1 bus = '{a, 1'b0, 1'b1, 1'b1, 1'b0, ~bus.data};
    while (n < 12 && !ok) begin
      @(posedge clock);
      #1 ok = (dq_oe_n === 1'b0);
      n++;
    end
    d = dq_out;
    @(posedge clock);
    #1 bus = '{a, 1'b1, 1'b0, 1'b1, 1'b1, bus.data};
    repeat (4) @(posedge clock);
  endtask
  // prolonged seconds read with stable address, counting lsb edges
  task automatic hold_sec(input int clocks, output int edges);
    logic last;
    edges = 0;
    @(posedge clock);
    #1 bus = '{13'h1ff9, 1'b0, 1'b1, 1'b1, 1'b0, bus.data};
    repeat (5) @(posedge clock);
    #1 last = dq_out[0];
    repeat (clocks) begin
      @(posedge clock);
      #1 edges += int'(dq_out[0] !== last);
      last = dq_out[0];
    end
    bus = '{13'h1ff9, 1'b1, 1'b0, 1'b1, 1'b1, bus.data};
    repeat (4) @(posedge clock);
  endtask
endmodule

// *** bcr_pkg.sv ***
/*
 * types of the bcd clock register core.
 * assumes the constants of bcr_cfg.svh are used alongside it.
 */
package bcr_pkg;

  // one byte of register data
  typedef logic [7:0] bcr_byte_type;

  // asynchronous memory bus pins as seen by the core
  typedef struct packed {
    logic [12:0] addr;        // byte address
    logic        chip_en1_n;  // chip enable 1, active low
    logic        chip_en2;    // chip enable 2, active high
    logic        write_n;     // write enable, active low
    logic        out_en_n;    // output enable, active low
    logic [7:0]  data;        // data lines as driven by the host
  } bcr_bus_type;

endpackage
